// ### core/gtc_timer.sv
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/1ns
// Functional notes
// - Sixteen-bit up-counter; software write replaces it.
// - Off unless on; gate enable restricts counting.
// - Undivided oscillator source adds four per cycle.
// - Falling pin edge needed before first count.
// - External source counts pin rising edges.
// - Prescaler divides by 1,2,4,8; hidden.
// - Count write clears prescale counter.
// - Bypass bit is stored only; external clock is always synchronized.
// - Sleep input is unused; synchronized counting continues during sleep.
// - Mode switch may lose or add one.
// - Byte reads while running stay valid.
// - Wide mode: low read latches high byte.
// - Wide mode: high read returns holding buffer.
// - Wide mode: high buffered, low loads both.
// - Wide high write keeps prescaler untouched.
// - Gated counting only when level matches polarity.
// - Toggle flip-flop; cleared while toggle off.
// - Single pulse: arm, count one pulse, disarm.
// - Clearing pulse mode clears arm; modes combine.
// - Gate level readable even when ungated.
// - Gate level falling edge sets gate flag.
// - Rollover past all-ones sets overflow flag.
module gtc_timer
	import gtc_pkg::*;
(
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         rst,
	// APB slave
	input  wire gtc_apb_req_t apb_req,
	output gtc_apb_rsp_t      apb_rsp,
	// Pins and sleep
	input  wire logic         external_clock_pin,
	input  wire logic         gate_signal,
	input  wire logic         sleep,
	// Events
	output logic              overflow_irq,
	output logic              gate_event_irq
);

	typedef struct packed {
		gtc_apb_rsp_t rsp;
		logic [15:0]  timer_count;
		logic [7:0]   high_buffer;
		logic [2:0]   prescale;
		gtc_ctrl_t    ctrl;
		gtc_gate_t    gate;
		logic         ovf_flag;
		logic         gate_event_flag;
		logic         gate_event_irq_enable;
		logic         fall_seen;
		logic         toggle_ff;
		logic         pulse_open;
		logic         gate_level_status;
		logic [1:0]   ext_sync;
		logic [1:0]   gate_sync;
		logic         ext_prev;
		logic         gate_prev;
		logic         ovf_irq;
		logic         gev_irq;
	} gtc_state_t;

	gtc_state_t st;
	gtc_state_t next_st;

	assign apb_rsp        = st.rsp;
	assign overflow_irq   = st.ovf_irq;
	assign gate_event_irq = st.gev_irq;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic        acc;
		logic        wr;
		logic        rd;
		logic        ext_rise;
		logic        ext_fall;
		logic        gate_in;
		logic        gate_lvl;
		logic        gate_ok;
		logic        tick;
		logic        run;
		logic [2:0]  mask;
		logic [15:0] step;
		logic [16:0] sum;
		logic [31:0] rdata;
		logic        bad;
		next_st = st;
		gate_ok = 1'b0;
		tick = 1'b0;
		sum = 17'h00000;
		bad = 1'b0;
		// Read data is captured in the wait cycle so it stands with pready;
		// writes take effect at the edge where pready is sampled high
		acc = apb_req.psel && apb_req.penable;
		wr = acc && st.rsp.pready && apb_req.pwrite;
		rd = acc && !st.rsp.pready && !apb_req.pwrite;
		rdata = 32'h0000_0000;
		next_st.ext_sync = {st.ext_sync[0], external_clock_pin};
		next_st.gate_sync = {st.gate_sync[0], gate_signal};
		next_st.ext_prev = st.ext_sync[1];
		next_st.gate_prev = st.gate_sync[1];
		ext_rise = st.ext_sync[1] && !st.ext_prev;
		ext_fall = !st.ext_sync[1] && st.ext_prev;
		// Bypass is ignored: the pin always passes the two sync stages
		ext_rise = st.ext_sync[1] && !st.ext_prev;
		// Gate path: polarity, then toggle flip-flop, then single pulse
		gate_in = st.gate_sync[1] ^ !st.gate.polarity;
		if (!st.gate.toggle_mode) begin
			next_st.toggle_ff = 1'b0;
		end else if (gate_in && !(st.gate_prev ^ !st.gate.polarity)) begin
			next_st.toggle_ff = !st.toggle_ff;
		end
		gate_lvl = st.gate.toggle_mode ? st.toggle_ff : gate_in;
		if (st.gate.single_pulse_mode) begin
			if (st.gate.pulse_arm_status && gate_lvl
					&& !st.gate_level_status) begin
				next_st.pulse_open = 1'b1;
			end
			if (st.pulse_open && !gate_lvl) begin
				next_st.pulse_open = 1'b0;
				next_st.gate.pulse_arm_status = 1'b0;
			end
			gate_ok = st.pulse_open && gate_lvl;
		end else begin
			next_st.pulse_open = 1'b0;
			gate_ok = gate_lvl;
		end
		next_st.gate_level_status = gate_lvl;
		if (st.gate_level_status && !gate_lvl) begin
			next_st.gate_event_flag = 1'b1;
		end
		// Clock source and edge qualification
		run = st.ctrl.on && (!st.gate.enable || gate_ok);
		case (st.ctrl.src)
			GTC_SRC_EXT: begin
				if (ext_fall) begin
					next_st.fall_seen = 1'b1;
				end
				tick = ext_rise && st.fall_seen;
			end
			default: tick = 1'b1;
		endcase
		if (!st.ctrl.on) begin
			next_st.fall_seen = 1'b0;
		end
		step = (st.ctrl.src == GTC_SRC_FOSC) ? {13'h0000, FOSC_STEP}
			: 16'h0001;
		mask = 3'((4'h1 << st.ctrl.prescale_select) - 4'h1);
		if (run && tick) begin
			if ((st.prescale & mask) == mask) begin
				next_st.prescale = PRESCALE_RESET;
				sum = {1'b0, st.timer_count} + {1'b0, step};
				next_st.timer_count = sum[15:0];
				if (sum[16]) begin
					next_st.ovf_flag = 1'b1;
				end
			end else begin
				next_st.prescale = st.prescale + 3'h1;
			end
		end
		// Register bus
		next_st.rsp.pready = 1'b0;
		if (acc) begin
			case (apb_req.paddr)
				ADDR_COUNT_LOW: begin
					rdata[7:0] = st.timer_count[7:0];
					if (rd && st.ctrl.wide) begin
						next_st.high_buffer = st.timer_count[15:8];
					end
					if (wr) begin
						next_st.timer_count[7:0] = apb_req.pwdata[7:0];
						if (st.ctrl.wide) begin
							next_st.timer_count[15:8] = st.high_buffer;
						end
						next_st.prescale = PRESCALE_RESET;
						next_st.fall_seen = 1'b0;
					end
				end
				ADDR_COUNT_HIGH: begin
					rdata[7:0] = st.ctrl.wide ? st.high_buffer
						: st.timer_count[15:8];
					if (wr && st.ctrl.wide) begin
						next_st.high_buffer = apb_req.pwdata[7:0];
					end else if (wr) begin
						next_st.timer_count[15:8] = apb_req.pwdata[7:0];
						next_st.prescale = PRESCALE_RESET;
						next_st.fall_seen = 1'b0;
					end
				end
				ADDR_CONTROL: begin
					rdata[CTL_ON] = st.ctrl.on;
					rdata[CTL_WIDE] = st.ctrl.wide;
					rdata[CTL_BYPASS] = st.ctrl.bypass;
					rdata[CTL_PS_LO +: 2] = st.ctrl.prescale_select;
					rdata[CTL_SRC_LO +: 2] = st.ctrl.src;
					if (wr) begin
						next_st.ctrl.on = apb_req.pwdata[CTL_ON];
						next_st.ctrl.wide = apb_req.pwdata[CTL_WIDE];
						next_st.ctrl.bypass = apb_req.pwdata[CTL_BYPASS];
						next_st.ctrl.prescale_select =
							apb_req.pwdata[CTL_PS_LO +: 2];
						next_st.ctrl.src = apb_req.pwdata[CTL_SRC_LO +: 2];
					end
				end
				ADDR_GATE_CTRL: begin
					rdata[GC_LEVEL] = st.gate_level_status;
					rdata[GC_ARM] = st.gate.pulse_arm_status;
					rdata[GC_SPM] = st.gate.single_pulse_mode;
					rdata[GC_TOGGLE] = st.gate.toggle_mode;
					rdata[GC_POL] = st.gate.polarity;
					rdata[GC_ENABLE] = st.gate.enable;
					if (wr) begin
						next_st.gate.enable = apb_req.pwdata[GC_ENABLE];
						next_st.gate.polarity = apb_req.pwdata[GC_POL];
						next_st.gate.toggle_mode = apb_req.pwdata[GC_TOGGLE];
						next_st.gate.single_pulse_mode =
							apb_req.pwdata[GC_SPM];
						next_st.gate.pulse_arm_status =
							apb_req.pwdata[GC_ARM]
							&& apb_req.pwdata[GC_SPM];
					end
				end
				ADDR_FLAGS: begin
					rdata[FL_OVF] = st.ovf_flag;
					rdata[FL_GATE] = st.gate_event_flag;
					rdata[FL_GATE_IEN] = st.gate_event_irq_enable;
					if (wr) begin
						// Write one clears; a same-cycle event wins only if the flag was clear
						if (apb_req.pwdata[FL_OVF] && !(next_st.ovf_flag
								&& !st.ovf_flag)) begin
							next_st.ovf_flag = 1'b0;
						end
						if (apb_req.pwdata[FL_GATE] && !(next_st.gate_event_flag
								&& !st.gate_event_flag)) begin
							next_st.gate_event_flag = 1'b0;
						end
						next_st.gate_event_irq_enable =
							apb_req.pwdata[FL_GATE_IEN];
					end
				end
				default: begin
					bad = 1'b1;
				end
			endcase
			if (!st.rsp.pready) begin
				next_st.rsp.prdata = rdata;
				next_st.rsp.pslverr = bad;
			end
		end
		if (st.rsp.pready && acc) begin
			next_st.rsp.pready = 1'b0;
		end else if (acc && !st.rsp.pready) begin
			next_st.rsp.pready = 1'b1;
		end
		next_st.ovf_irq = next_st.ovf_flag;
		next_st.gev_irq = next_st.gate_event_flag
			&& next_st.gate_event_irq_enable;
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

endmodule // gtc_timer

// ### core/gtc_pkg.sv
package gtc_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_COUNT_LOW  = 8'h00;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'h04;
	localparam logic [7:0] ADDR_CONTROL    = 8'h08;
	localparam logic [7:0] ADDR_GATE_CTRL  = 8'h0C;
	localparam logic [7:0] ADDR_FLAGS      = 8'h10;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTL_ON     = 0;
	localparam int CTL_WIDE   = 1;
	localparam int CTL_BYPASS = 2;
	localparam int CTL_PS_LO  = 4;
	localparam int CTL_SRC_LO = 6;

	// ----------------------------------------------------------------
	// Gate control register fields
	// ----------------------------------------------------------------
	localparam int GC_LEVEL  = 2;
	localparam int GC_ARM    = 3;
	localparam int GC_SPM    = 4;
	localparam int GC_TOGGLE = 5;
	localparam int GC_POL    = 6;
	localparam int GC_ENABLE = 7;

	// ----------------------------------------------------------------
	// Flags register fields
	// ----------------------------------------------------------------
	localparam int FL_OVF      = 0;
	localparam int FL_GATE     = 1;
	localparam int FL_GATE_IEN = 2;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [15:0] COUNT_RESET    = 16'h0000;
	localparam logic [2:0]  PRESCALE_RESET = 3'h0;
	localparam logic [2:0]  FOSC_STEP      = 3'h4;

	// ----------------------------------------------------------------
	// Clock sources
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		GTC_SRC_INSTR,
		GTC_SRC_FOSC,
		GTC_SRC_EXT
	} gtc_src_t;

	typedef struct packed {
		logic [7:0]  paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} gtc_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} gtc_apb_rsp_t;

	typedef struct packed {
		logic       on;
		logic       wide;
		logic       bypass;
		logic [1:0] prescale_select;
		logic [1:0] src;
	} gtc_ctrl_t;

	typedef struct packed {
		logic enable;
		logic polarity;
		logic toggle_mode;
		logic single_pulse_mode;
		logic pulse_arm_status;
	} gtc_gate_t;

endpackage

// ### testbench/gtc_checker.sv
`timescale 1ns/1ns
module gtc_checker
	import gtc_pkg::*;
(
	// Clock and reset
	input wire logic         clk_sys,
	input wire logic         rst,
	// Register bus
	input wire gtc_apb_req_t apb_req,
	input wire gtc_apb_rsp_t apb_rsp,
	// Events
	input wire logic         overflow_irq,
	input wire logic         gate_event_irq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic acc, rdy, hit, fw, clr_now, clr_q;
	assign acc = apb_req.psel && apb_req.penable;
	assign rdy = apb_rsp.pready;
	assign hit = apb_req.paddr inside {ADDR_COUNT_LOW, ADDR_COUNT_HIGH,
		ADDR_CONTROL, ADDR_GATE_CTRL, ADDR_FLAGS};
	assign fw = rdy && apb_req.pwrite && apb_req.paddr == ADDR_FLAGS;
	assign clr_now = fw && apb_req.pwdata[FL_OVF];
	// Overflow clear may show one cycle late on the pin
	always_ff @(posedge clk_sys) clr_q <= clr_now;
	sequence s_setup; apb_req.psel && !apb_req.penable; endsequence
	sequence s_answer; !rdy ##1 rdy; endsequence
	property p_wait; s_setup ##1 acc |-> s_answer; endproperty
	property p_pulse; rdy |=> !rdy; endproperty
	property p_inacc; rdy |-> acc; endproperty
	property p_err; rdy |-> apb_rsp.pslverr == !hit; endproperty
	property p_zero;
		rdy && !hit && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0;
	endproperty
	property p_hold;
		!rdy |-> $stable(apb_rsp.prdata) && $stable(apb_rsp.pslverr);
	endproperty
	property p_ovf;
		overflow_irq && !clr_now && !clr_q |=> overflow_irq;
	endproperty
	property p_ien;
		fw && !apb_req.pwdata[FL_GATE_IEN] |-> ##2 !gate_event_irq;
	endproperty
	a_wait: assert property (p_wait) else $error("bad wait");
	a_pulse: assert property (p_pulse) else $error("long ready");
	a_inacc: assert property (p_inacc) else $error("stray ready");
	a_err: assert property (p_err) else $error("bad slverr");
	a_zero: assert property (p_zero) else $error("bad refused data");
	a_hold: assert property (p_hold) else $error("data moved");
	a_ovf: assert property (p_ovf) else $error("overflow lost");
	a_ien: assert property (p_ien) else $error("gate irq stuck");
endmodule // gtc_checker

bind gtc_timer gtc_checker i_chk (
	.clk_sys(clk_sys), .rst(rst), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.overflow_irq(overflow_irq), .gate_event_irq(gate_event_irq)
);

// ### testbench/gtc_pin_model.sv
`timescale 1ns/1ns
module gtc_pin_model (
	// Clock
	input  wire logic       clk_sys,
	// Commands from the bench
	input  wire logic [3:0] npulse,
	input  wire logic       gate_lvl,
	// Pins
	output logic            external_clock_pin,
	output logic            gate_signal,
	output logic            busy
);
	logic [6:0] cnt = 7'h00;
	// Each pulse is 4 cycles high then 4 low; the pin idles low
	always_ff @(posedge clk_sys)
		if (cnt != 7'h00) cnt <= cnt - 7'h01;
		else cnt <= {npulse, 3'h0};
	assign external_clock_pin = cnt[2];
	assign gate_signal = gate_lvl;
	assign busy = cnt != 7'h00;
endmodule // gtc_pin_model

// ### testbench/gated_16bit_timer_counter_tb_top.sv
`timescale 1ns/1ns
module gated_16bit_timer_counter_tb_top
	import gtc_pkg::*;
;
	logic         clk_sys = 1'b0;
	logic         rst = 1'b1;
	gtc_apb_req_t req = '0;
	gtc_apb_rsp_t rsp;
	logic         slp = 1'b0;
	logic         gl = 1'b0;
	logic [3:0]   np = 4'h0;
	logic         ovf, gie, ext, gate, busy;
	logic [31:0]  q, c;
	int           err_count = 0;
	int           compares = 0;
	initial forever #50 clk_sys = ~clk_sys;
	gtc_timer i_dut (.clk_sys(clk_sys), .rst(rst), .apb_req(req),
		.apb_rsp(rsp), .external_clock_pin(ext), .gate_signal(gate),
		.sleep(slp), .overflow_irq(ovf), .gate_event_irq(gie));
	gtc_pin_model i_pins (.clk_sys(clk_sys), .npulse(np), .gate_lvl(gl),
		.external_clock_pin(ext), .gate_signal(gate), .busy(busy));
	task automatic report_and_stop;
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			$display("wrong value at %0t: %h not %h", $time, g, e);
			err_count++;
		end
	endtask
	task automatic xfer(input logic [7:0] a, input logic w,
		input logic [31:0] d);
		int n = 0;
		req <= '{a, 1'b1, 1'b0, w, d};
		@(posedge clk_sys);
		req.penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (rsp.pready !== 1'b1 && n < 20);
		q = rsp.prdata;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (n >= 20) begin
			err_count++;
			report_and_stop();
		end
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		xfer(a, 1'b0, 32'h0);
		chk(q, e);
	endtask
	task automatic pulse(input logic [3:0] n);
		int k;
		np <= n;
		@(posedge clk_sys);
		np <= 4'h0;
		for (k = 0; k < 200 && (busy || k < 2); k++) @(posedge clk_sys);
		if (busy) begin
			err_count++;
			report_and_stop();
		end
		repeat (4) @(posedge clk_sys);
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		// Polarity clear and gate pin low: gate level reads active
		for (int a = 0; a < 24; a += 4)
			rd(8'(a), (a == 12) ? 32'h4 : 32'h0);
		wr(8'h14, 32'hFF);
		wr(8'h04, 32'h12);
		wr(8'h00, 32'h34);
		repeat (10) @(posedge clk_sys);
		rd(8'h00, 32'h34);
		rd(8'h04, 32'h12);
		for (int p = 0; p < 4; p++) begin
			slp <= p[1];
			c = {24'h0, 2'h2, 2'(p), 1'b0, p[0], 2'h0};
			wr(8'h08, c);
			wr(8'h04, 32'h0);
			wr(8'h00, 32'h0);
			wr(8'h08, c | 32'h1);
			pulse(4'd9);
			rd(8'h00, 32'h8 >> p);
		end
		slp <= 1'b0;
		wr(8'h08, 32'h02);
		wr(8'h04, 32'hAB);
		wr(8'h00, 32'hCD);
		rd(8'h00, 32'hCD);
		wr(8'h04, 32'h55);
		rd(8'h04, 32'h55);
		rd(8'h00, 32'hCD);
		rd(8'h04, 32'hAB);
		wr(8'h08, 32'h40);
		wr(8'h00, 32'h02);
		wr(8'h08, 32'h41);
		wr(8'h08, 32'h40);
		xfer(8'h00, 1'b0, 32'h0);
		chk({30'h0, q[1:0]}, 32'h2);
		chk(32'(q != 32'h2), 32'h1);
		wr(8'h04, 32'hFF);
		wr(8'h00, 32'hFF);
		wr(8'h08, 32'h01);
		repeat (20) @(posedge clk_sys);
		wr(8'h08, 32'h00);
		chk({31'h0, ovf}, 32'h1);
		rd(8'h10, 32'h1);
		wr(8'h10, 32'h1);
		rd(8'h10, 32'h0);
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h0);
		wr(8'h0C, 32'hC0);
		wr(8'h08, 32'h01);
		repeat (10) @(posedge clk_sys);
		wr(8'h08, 32'h00);
		rd(8'h00, 32'h0);
		wr(8'h0C, 32'h40);
		wr(8'h10, 32'h2);
		gl <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rd(8'h0C, 32'h44);
		gl <= 1'b0;
		repeat (4) @(posedge clk_sys);
		rd(8'h10, 32'h2);
		wr(8'h10, 32'h4);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, gie}, 32'h1);
		wr(8'h10, 32'h2);
		repeat (2) @(posedge clk_sys);
		chk({31'h0, gie}, 32'h0);
		rd(8'h10, 32'h0);
		wr(8'h0C, 32'h58);
		rd(8'h0C, 32'h58);
		wr(8'h0C, 32'h40);
		rd(8'h0C, 32'h40);
		report_and_stop();
	end
endmodule // gated_16bit_timer_counter_tb_top
